// ===== rtl/hic_pkg.sv
// Shared constants and types for the host I/O channel interface.
// Assumes a 10 MHz system clock and software access over classic Wishbone.
package hic_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int UPD_PULSE_NS  = 200;
	localparam int RDY_WAIT_NS   = 100;
	localparam int UPD_PULSE_CYC = (UPD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RDY_WAIT_CYC  = (RDY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Host bus geometry
	localparam int SA_W   = 10;
	localparam int SEL_W  = 5;
	localparam int BASE_W = 5;
	localparam int NREG   = 32;
	localparam int NIRQ   = 11;
	localparam int NDRQ   = 8;
	localparam int CODE_W = 12;
	localparam int NINT   = 3;

	// Wishbone byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MASK   = 8'h08;
	localparam logic [7:0] OFS_CLEAR  = 8'h0c;
	localparam logic [7:0] OFS_CODE   = 8'h10;

	// Interrupt status bit positions
	localparam int INT_HALF = 0;
	localparam int INT_TC   = 1;
	localparam int INT_UPD  = 2;

	// Control register field positions
	localparam int CTL_BASE_LSB = 0;
	localparam int CTL_IRQ_LSB  = 5;
	localparam int CTL_DMAEN    = 9;
	localparam int CTL_DCH_LSB  = 10;
	localparam int CTL_EISA     = 13;
	localparam int CTL_TWOS     = 14;
	localparam int CTL_W        = 15;

	// Reset values
	localparam logic [CTL_W-1:0]  CTRL_RST = 15'h01f0;
	localparam logic [NINT-1:0]   MASK_RST = 3'h0;
	localparam logic [CODE_W-1:0] CODE_RST = 12'h000;
	localparam logic [CODE_W-1:0] CODE_MSB = 12'h800;

	// Control fields as one carrier
	typedef struct packed {
		logic       fmt_twos;
		logic       eisa;
		logic [2:0] dma_ch;
		logic       dma_en;
		logic [3:0] irq_sel;
		logic [4:0] base;
	} hic_ctrl_t;

	// Host I/O cycle request signals
	typedef struct packed {
		logic            bale;
		logic            ior_n;
		logic            iow_n;
		logic            sbhe_n;
		logic [SA_W-1:0] sa;
	} hic_isa_t;

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} hic_cyc_t;
endpackage

// ===== rtl/hic_top.sv
// Host I/O channel interface of an analog output board: address latch and
// decode, buffer steering, interrupt routing, DMA request and update pulse.
// Assumes all inputs synchronous to clk_i and a classic Wishbone master.
// Summary of operation
// - Ten host address lines are decoded, board space 000 to 3FF hex.
// - Board enable compares latched SA9..SA5 against the configured base.
// - Latched SA4..SA0 select the onboard register accessed.
// - Address is latched at transfer start and held until cycle ends.
// - One register-select strobe per register, from the latched address.
// - Data buffer direction follows read or write of the transfer.
// - Transfers are 8 or 16 bits, strobes from host timing signals.
// - Board reports access, readiness and transfer width to the host.
// - Interrupt request pins are tri-state so lines can be shared.
// - Enabled requests go to one selected line of IRQ3-7, 9-12, 14, 15.
// - Interrupts from FIFO half full, DMA terminal count, update falling edge.
// - Each interrupt source has its own enable and its own clear.
// - DMA request while DMA enabled and FIFO not full, otherwise none.
// - 16-bit DMA on channel 5, 6 or 7, or 0 to 3 on EISA.
// - DAC codes are 12 bits; unipolar code zero means zero volts.
// - Bipolar format bit: straight binary 2048 or two's complement 0 is zero.
// - External update falling edge makes a low pulse; edges start update, request data.
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module hic_top
	import hic_pkg::*;
(
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	// Wishbone slave
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [7:0]               wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	// Host I/O channel
	input  wire hic_pkg::hic_isa_t        isa_i,
	output logic                          board_acc_o,
	output logic                          ready_o,
	output logic                          io16_n_o,
	output logic                          xfer16_o,
	output logic [hic_pkg::NREG-1:0]      reg_sel_o,
	output logic                          buf_oe_o,
	output logic                          buf_dir_o,
	output logic [hic_pkg::NIRQ-1:0]      irq_line_o,
	output logic [hic_pkg::NIRQ-1:0]      irq_line_oe_o,
	output logic [hic_pkg::NDRQ-1:0]      drq_o,
	input  wire logic                     dma_tc_i,
	// FIFO and update
	input  wire logic                     fifo_full_i,
	input  wire logic                     fifo_half_i,
	input  wire logic                     ext_update_in_n,
	input  wire logic                     int_update_i,
	output logic                          update_pulse_n,
	output logic                          data_req_o,
	output logic [hic_pkg::CODE_W-1:0]    dac_code_o,
	output logic                          irq_o
);
	import hic_pkg::*;

	// Decode an interrupt line selection to a one-hot pin vector, all zero for selections 11 to 15
	function automatic logic [NIRQ-1:0] irq_dec(input logic [3:0] s);
		logic [NIRQ-1:0] v;
		v = '0;
		if (s < 4'(NIRQ)) begin
			v[s] = 1'b1;
		end
		return v;
	endfunction

	// Decode a DMA channel selection; only legal channels for the bus mode
	function automatic logic [NDRQ-1:0] drq_dec(input logic [2:0] c, input logic eisa);
		logic [NDRQ-1:0] v;
		v = '0;
		if ((eisa && c <= 3'h3) || (!eisa && c >= 3'h5)) begin
			v[c] = 1'b1;
		end
		return v;
	endfunction

	hic_ctrl_t          ctrl;
	logic [NINT-1:0]    status;
	logic [NINT-1:0]    mask;
	logic [CODE_W-1:0]  code;
	logic [SA_W-1:0]    sa_lat;
	hic_cyc_t           cyc;
	logic [1:0]         wait_cnt;
	logic [1:0]         pulse_cnt;
	logic               ext_prev;
	logic               upd_prev;
	logic               half_prev;
	logic               tc_prev;

	// Wishbone decode
	wire                wb_req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire                wb_wr      = wb_req && wb_we_i;
	wire                wb_rd      = wb_req && !wb_we_i;
	wire                hit_ctrl   = wb_adr_i == OFS_CTRL;
	wire                hit_status = wb_adr_i == OFS_STATUS;
	wire                hit_mask   = wb_adr_i == OFS_MASK;
	wire                hit_clear  = wb_adr_i == OFS_CLEAR;
	wire                hit_code   = wb_adr_i == OFS_CODE;
	wire                lo_en      = wb_sel_i[0];
	wire                hi_en      = wb_sel_i[1];

	// Read data selection
	logic [31:0]        rd_data;
	always_comb begin
		rd_data = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_data = {17'h0, ctrl};
		end else if (hit_status) begin
			rd_data = {29'h0, status};
		end else if (hit_mask) begin
			rd_data = {29'h0, mask};
		end else if (hit_code) begin
			rd_data = {20'h0, code};
		end
	end

	// Control fields with byte lanes
	wire [CTL_W-1:0]    ctrl_wr = {hi_en ? wb_dat_i[CTL_W-1:8] : ctrl[CTL_W-1:8],
	                               lo_en ? wb_dat_i[7:0] : ctrl[7:0]};
	wire [CODE_W-1:0]   code_wr = {hi_en ? wb_dat_i[CODE_W-1:8] : code[CODE_W-1:8],
	                               lo_en ? wb_dat_i[7:0] : code[7:0]};

	// Bus answer one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_rd ? rd_data : 32'h0000_0000;
		end
	end

	// Software-writable control, mask and code
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= hic_ctrl_t'(CTRL_RST);
			mask <= MASK_RST;
			code <= CODE_RST;
		end else begin
			if (wb_wr && hit_ctrl) begin
				ctrl <= hic_ctrl_t'(ctrl_wr);
			end
			if (wb_wr && hit_mask && lo_en) begin
				mask <= wb_dat_i[NINT-1:0];
			end
			if (wb_wr && hit_code) begin
				code <= code_wr;
			end
		end
	end

	// Interrupt events from the three sources
	wire                upd_fall = upd_prev && !update_pulse_n;
	wire [NINT-1:0]     ev;
	assign ev[INT_HALF] = fifo_half_i && !half_prev;
	assign ev[INT_TC]   = dma_tc_i && !tc_prev;
	assign ev[INT_UPD]  = upd_fall;

	// Per-source clears: read of status clears all, clear register clears chosen bits
	wire [NINT-1:0]     clr = (wb_rd && hit_status) ? {NINT{1'b1}} :
	                          (wb_wr && hit_clear && lo_en) ? wb_dat_i[NINT-1:0] : '0;
	wire [NINT-1:0]     next_status = (status & ~clr) | ev;

	// Sticky status bits, set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status    <= '0;
			half_prev <= 1'b0;
			tc_prev   <= 1'b0;
			upd_prev  <= 1'b1;
		end else begin
			status    <= next_status;
			half_prev <= fifo_half_i;
			tc_prev   <= dma_tc_i;
			upd_prev  <= update_pulse_n;
		end
	end

	// Interrupt request routing to one selected tri-state line
	wire                irq_next = |(next_status & mask);
	wire [NIRQ-1:0]     irq_pins = irq_dec(ctrl.irq_sel);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o         <= 1'b0;
			irq_line_o    <= '0;
			irq_line_oe_o <= '0;
		end else begin
			irq_o         <= irq_next;
			irq_line_o    <= irq_next ? irq_pins : '0;
			irq_line_oe_o <= irq_next ? irq_pins : '0;
		end
	end

	// DMA request on the selected channel
	wire [NDRQ-1:0]     drq_pins = drq_dec(ctrl.dma_ch, ctrl.eisa);
	wire                drq_on   = ctrl.dma_en && !fifo_full_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drq_o <= '0;
		end else begin
			drq_o <= drq_on ? drq_pins : '0;
		end
	end

	// Update pulse: a falling edge of the external update input, or the internal update input high, starts a low pulse
	wire                ext_fall  = ext_prev && !ext_update_in_n;
	wire                upd_start = (ext_fall || int_update_i) && pulse_cnt == 2'h0;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_prev       <= 1'b1;
			pulse_cnt      <= 2'h0;
			update_pulse_n <= 1'b1;
			data_req_o     <= 1'b0;
		end else begin
			ext_prev   <= ext_update_in_n;
			data_req_o <= 1'b0;
			if (upd_start) begin
				pulse_cnt      <= 2'(UPD_PULSE_CYC);
				update_pulse_n <= 1'b0;
			end else if (pulse_cnt == 2'h1) begin
				pulse_cnt      <= 2'h0;
				update_pulse_n <= 1'b1;
				data_req_o     <= 1'b1;
			end else if (pulse_cnt != 2'h0) begin
				pulse_cnt <= pulse_cnt - 2'h1;
			end
		end
	end

	// Code format: two's complement flips the sign bit to straight binary
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dac_code_o <= CODE_RST;
		end else begin
			dac_code_o <= ctrl.fmt_twos ? (code ^ CODE_MSB) : code;
		end
	end

	// Host cycle decode from the latched address
	wire                strobe   = !isa_i.ior_n || !isa_i.iow_n;
	wire                board_en = sa_lat[SA_W-1:SEL_W] == ctrl.base;
	wire                access   = strobe && board_en;
	wire [NREG-1:0]     sel_hot  = NREG'(1) << sa_lat[SEL_W-1:0];
	// Ready stays low on the access edge and for all but the last counted wait cycle
	wire                hold_rdy = cyc == ST_IDLE || (cyc == ST_WAIT && wait_cnt != 2'h1);

	// Address latch: captured only between transfers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sa_lat <= '0;
		end else if (cyc == ST_IDLE && !strobe && isa_i.bale) begin
			sa_lat <= isa_i.sa;
		end
	end

	// Transfer state: a short wait, then ready until the strobe ends
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cyc      <= ST_IDLE;
			wait_cnt <= 2'h0;
		end else begin
			case (cyc)
				ST_IDLE: begin
					if (access) begin
						cyc      <= ST_WAIT;
						wait_cnt <= 2'(RDY_WAIT_CYC);
					end
				end
				ST_WAIT: begin
					if (!strobe) begin
						cyc <= ST_IDLE;
					end else if (wait_cnt == 2'h1) begin
						cyc <= ST_DONE;
					end else begin
						wait_cnt <= wait_cnt - 2'h1;
					end
				end
				default: begin
					if (!strobe) begin
						cyc <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Host-facing indications and buffer steering
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			board_acc_o <= 1'b0;
			ready_o     <= 1'b1;
			io16_n_o    <= 1'b1;
			xfer16_o    <= 1'b0;
			reg_sel_o   <= '0;
			buf_oe_o    <= 1'b0;
			buf_dir_o   <= 1'b0;
		end else begin
			board_acc_o <= access;
			ready_o     <= !(access && hold_rdy);
			io16_n_o    <= !board_en;
			xfer16_o    <= access && !isa_i.sbhe_n;
			reg_sel_o   <= access ? sel_hot : '0;
			buf_oe_o    <= access;
			buf_dir_o   <= access && !isa_i.ior_n;
		end
	end

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_access;
		access ##1 access;
	endsequence

	latch_hold_a: assert property (strobe && $past(strobe) |-> $stable(sa_lat))
		else $error("latched address changed during transfer");
	sel_onehot_a: assert property (s_access |-> $onehot(reg_sel_o) && reg_sel_o == sel_hot)
		else $error("register select not one-hot");
	board_en_a: assert property (strobe && !board_en |=> !board_acc_o && reg_sel_o == '0)
		else $error("foreign address accessed");
	buf_dir_a: assert property (access && !isa_i.ior_n |=> buf_dir_o && buf_oe_o)
		else $error("read did not turn buffers");
	ready_wait_a: assert property (cyc == ST_IDLE && access |=> !ready_o)
		else $error("no wait state on access");
	drq_gate_a: assert property (fifo_full_i || !ctrl.dma_en |=> drq_o == '0)
		else $error("DMA request while full or disabled");
	drq_legal_a: assert property ((drq_o & (ctrl.eisa ? 8'hf0 : 8'h1f)) == '0 || $changed(ctrl))
		else $error("DMA request on illegal channel");
	irq_line_a: assert property (irq_line_oe_o != '0 |-> $onehot(irq_line_oe_o) && irq_o)
		else $error("interrupt line drive wrong");
	sticky_a: assert property (status[INT_TC] && !(wb_rd && hit_status) && !clr[INT_TC]
		|=> status[INT_TC])
		else $error("status bit lost without clear");
	mask_gate_a: assert property ((status & mask) == '0 && $stable(mask) |-> !irq_o)
		else $error("masked source raised interrupt");
	pulse_width_a: assert property ($fell(update_pulse_n) |-> !update_pulse_n [*2] ##1 update_pulse_n)
		else $error("update pulse width wrong");
	upd_int_a: assert property ($fell(update_pulse_n) |=> status[INT_UPD])
		else $error("update edge did not set status");
	fmt_a: assert property (ctrl.fmt_twos && $stable(ctrl) && $stable(code)
		|=> dac_code_o == ($past(code) ^ CODE_MSB))
		else $error("two's complement conversion wrong");
	code_a: assert property (!ctrl.fmt_twos && $stable(ctrl) && $stable(code)
		|=> dac_code_o == $past(code))
		else $error("straight code altered");

	// Wait state of an accepted host cycle: one low cycle, then ready again
	sequence s_strobe_hit;
		cyc == ST_IDLE && access;
	endsequence

	sequence s_ready_back;
		!ready_o ##1 ready_o;
	endsequence

	ready_back_a: assert property (s_strobe_hit |=> s_ready_back)
		else $error("ready not returned after wait");

	// Each event source records its own status bit
	half_int_a: assert property ($rose(fifo_half_i) |=> status[INT_HALF])
		else $error("half full event not recorded");
	tc_int_a: assert property ($rose(dma_tc_i) |=> status[INT_TC])
		else $error("terminal count not recorded");

	// Requests land on the selected line and the enabled DMA channel
	irq_route_a: assert property (ctrl.irq_sel < 4'(NIRQ) && $stable(ctrl.irq_sel)
		|-> irq_line_oe_o[ctrl.irq_sel] == irq_o)
		else $error("interrupt on wrong line");
	drq_on_a: assert property (ctrl.dma_en && !fifo_full_i && !ctrl.eisa
		&& ctrl.dma_ch >= 3'h5 |=> drq_o != '0)
		else $error("DMA request withheld");
	width_a: assert property (access && !isa_i.sbhe_n |=> xfer16_o && board_acc_o)
		else $error("16-bit transfer not reported");
endmodule

// ===== verif/hic_host_model.sv
// Host bus and DMA controller model that drives I/O cycles into the board.
// Assumes the bench calls its tasks; signals change just after clk_i rises.
`timescale 1ns/1ps
module hic_host_model (
	input  wire logic         clk_i,
	output hic_pkg::hic_isa_t isa_o,
	output logic              dma_tc_o
);
	import hic_pkg::*;

	// Idle bus at time zero
	initial begin
		isa_o = '{bale: 1'b0, ior_n: 1'b1, iow_n: 1'b1, sbhe_n: 1'b1, sa: '0};
		dma_tc_o = 1'b0;
	end

	// Address phase, then a read or write strobe of 8 or 16 bits
	task automatic io_start(input logic [SA_W-1:0] a, input logic rd, input logic w16);
		@(posedge clk_i);
		isa_o.bale   <= 1'b1;
		isa_o.sa     <= a;
		isa_o.sbhe_n <= ~w16;
		@(posedge clk_i);
		isa_o.bale  <= 1'b0;
		isa_o.ior_n <= ~rd;
		isa_o.iow_n <= rd;
	endtask

	// Strobe release; the released address lines carry junk
	task automatic io_end();
		@(posedge clk_i);
		isa_o.ior_n <= 1'b1;
		isa_o.iow_n <= 1'b1;
		isa_o.sa    <= ~isa_o.sa;
	endtask

	// One-cycle terminal count pulse
	task automatic tc_pulse();
		@(posedge clk_i);
		dma_tc_o <= 1'b1;
		@(posedge clk_i);
		dma_tc_o <= 1'b0;
	endtask
endmodule

// ===== verif/host_io_channel_interface_bench.sv
// Self-checking bench for the host I/O channel interface.
// Assumes hic_top, hic_host_model and the hic_pkg constants.
`timescale 1ns/1ps
module host_io_channel_interface_bench;
	import hic_pkg::*;
	logic              clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dma_tc;
	logic [7:0]        wb_adr_i;
	logic [3:0]        wb_sel_i;
	logic [31:0]       wb_dat_i, wb_dat_o, rd;
	hic_isa_t          isa;
	logic              board_acc_o, ready_o, io16_n_o, xfer16_o, buf_oe_o, buf_dir_o;
	logic [NREG-1:0]   reg_sel_o;
	logic [NIRQ-1:0]   irq_line_o, irq_line_oe_o;
	logic [NDRQ-1:0]   drq_o;
	logic              fifo_full_i, fifo_half_i, ext_update_in_n, int_update_i;
	logic              update_pulse_n, data_req_o, irq_o, m, r, w, lg;
	logic [CODE_W-1:0] dac_code_o, c;
	logic [SA_W-1:0]   a;
	logic [4:0]        base;
	int                err_total, checks_done, i, k, lows, reqs;

	hic_top i_hic_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .isa_i(isa), .board_acc_o, .ready_o, .io16_n_o,
		.xfer16_o, .reg_sel_o, .buf_oe_o, .buf_dir_o, .irq_line_o, .irq_line_oe_o, .drq_o,
		.dma_tc_i(dma_tc), .fifo_full_i, .fifo_half_i, .ext_update_in_n, .int_update_i,
		.update_pulse_n, .data_req_o, .dac_code_o, .irq_o);
	hic_host_model i_hic_host_model (.clk_i, .isa_o(isa), .dma_tc_o(dma_tc));

	// 10 MHz clock
	initial clk_i = 1'b0;
	always #50 clk_i = ~clk_i;

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Classic Wishbone single cycle, waits for ack
	task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= ad;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		chk(n < 50, 1'b1, "ack wait");
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// Control word from its fields
	function automatic logic [31:0] ctl(input logic [3:0] q, input logic de, input logic [2:0] ch,
		input logic ei, input logic tw);
		return {17'h0, tw, ei, ch, de, q, base};
	endfunction

	// Raise one interrupt event; update events also measure the pulse
	task automatic fire(input int e);
		if (e == 0) begin
			fifo_half_i <= 1'b1;
			@(posedge clk_i);
			fifo_half_i <= 1'b0;
		end else if (e == 1) begin
			i_hic_host_model.tc_pulse();
		end else begin
			ext_update_in_n <= k[0];
			int_update_i    <= k[0];
			lows = 0;
			reqs = 0;
			repeat (8) begin
				@(posedge clk_i);
				int_update_i <= 1'b0;
				#1 lows += int'(!update_pulse_n);
				reqs += int'(data_req_o);
			end
			ext_update_in_n <= 1'b1;
			chk(lows, 2, "pulse width");
			chk(reqs, 1, "data request");
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		give_verdict();
	end

	// Main sequence
	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {1'b1, 43'h0};
		{fifo_full_i, fifo_half_i, ext_update_in_n, int_update_i} = 4'b0010;
		{err_total, checks_done, wb_sel_i} = {64'h0, 4'h3};
		k = $urandom(30943);
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1 chk({io16_n_o, ready_o, update_pulse_n, irq_o, board_acc_o, drq_o}, 13'h1c00, "idle");
		wb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, {17'h0, CTRL_RST}, "ctrl reset");
		wb(1'b0, OFS_MASK, 32'h0);
		chk(rd, 32'h0, "mask reset");
		wb(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		// Host transfers at random addresses, every odd-numbered one forced onto the board
		base = 5'($urandom);
		wb(1'b1, OFS_CTRL, ctl(4'hf, 1'b0, 3'h0, 1'b0, 1'b0));
		for (i = 0; i < 24; i++) begin
			a = 10'($urandom);
			if (i[0])
				a[9:5] = base;
			{r, w} = 2'($urandom);
			m = (a[9:5] == base);
			i_hic_host_model.io_start(a, r, w);
			@(posedge clk_i);
			#1 chk({board_acc_o, buf_oe_o, buf_dir_o, xfer16_o, ready_o, io16_n_o},
				{m, m, r & m, w & m, ~m, ~m}, "access");
			chk(reg_sel_o, m ? 32'h1 << a[4:0] : 32'h0, "select");
			@(posedge clk_i);
			#1 chk(ready_o, 1'b1, "ready again");
			i_hic_host_model.io_end();
			repeat (2) @(posedge clk_i);
			#1 chk({board_acc_o, buf_oe_o}, 2'b00, "released");
			chk(reg_sel_o, 32'h0, "select released");
		end
		// Masked event never requests, status still records it
		wb(1'b1, OFS_MASK, 32'h0);
		fire(0);
		repeat (3) @(posedge clk_i);
		#1 chk({irq_o, irq_line_oe_o}, 12'h0, "masked");
		wb(1'b0, OFS_STATUS, 32'h0);
		chk(rd[2:0], 3'b001, "status half");
		// Each line with one source in turn, cleared by write or by read
		for (k = 0; k < 11; k++) begin
			wb(1'b1, OFS_CTRL, ctl(4'(k), 1'b0, 3'h0, 1'b0, 1'b0));
			wb(1'b1, OFS_MASK, 32'h1 << (k % 3));
			fire(k % 3);
			repeat (3) @(posedge clk_i);
			#1 chk({irq_o, irq_line_o, irq_line_oe_o}, {1'b1, {2{11'h1 << k}}}, "line");
			repeat (4) @(posedge clk_i);
			#1 chk(irq_o, 1'b1, "latched");
			if (k[0])
				wb(1'b0, OFS_STATUS, 32'h0);
			else
				wb(1'b1, OFS_CLEAR, 32'h1 << (k % 3));
			repeat (2) @(posedge clk_i);
			#1 chk({irq_o, irq_line_oe_o}, 12'h0, "cleared");
		end
		// DMA channel, mode, enable and full combinations
		for (k = 0; k < 24; k++) begin
			{m, r} = 2'($urandom);
			wb(1'b1, OFS_CTRL, ctl(4'hf, m, 3'(k), k[3], 1'b0));
			fifo_full_i <= r;
			repeat (3) @(posedge clk_i);
			lg = k[3] ? (k[2:0] <= 3) : (k[2:0] >= 5);
			#1 chk(drq_o, (lg && m && !r) ? 8'h1 << k[2:0] : 8'h0, "dma request");
		end
		// Code formats, with the sign boundary first
		for (k = 0; k < 8; k++) begin
			c = (k < 2) ? CODE_MSB : 12'($urandom);
			wb(1'b1, OFS_CTRL, ctl(4'hf, 1'b0, 3'h0, 1'b0, k[0]));
			wb(1'b1, OFS_CODE, 32'(c));
			repeat (2) @(posedge clk_i);
			#1 chk(dac_code_o, k[0] ? c ^ CODE_MSB : c, "code");
		end
		give_verdict();
	end
endmodule
